// [hdl/rxw_pkg.sv]
// package: constants, configuration carriers and states of the wake polling controller
`default_nettype none
package rxw_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RC_HZ = 40_000; // trimmed rc oscillator target
  localparam int unsigned RC_CLKS = CLK_HZ / RC_HZ; // system clocks per rc period
  localparam int unsigned CAL_N = 16; // rc periods measured per calibration pass
  localparam int unsigned CAL_TOL_PPM = 1000; // 0.1 percent
  localparam logic [15:0] CAL_TARGET = 16'(CAL_N * RC_CLKS);
  localparam logic [15:0] CAL_TOL = 16'(CAL_N * RC_CLKS * CAL_TOL_PPM / 1_000_000);
  localparam logic [4:0] CAL_LAST = 5'(CAL_N - 1);
  localparam logic [15:0] AGC_LAST = 16'h0003; // agc settling is 4 bit periods
  // ==========================================================
  // widths and reset values
  localparam int SYNC_W = 16;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [7:0] TRIM_MAX = 8'hFF;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic wor_en; // periodic_wake_polling enable
    logic [15:0] sleep_ival; // rc periods per wake
    logic [15:0] listen_bits; // listen window, bit periods
    logic [15:0] bit_period; // system clocks per bit
    logic div_en; // antenna diversity enable
    logic diff_en; // complementary antenna select
    logic valid_sel; // 0 signal strength, 1 preamble detector
    logic [7:0] dwell_bits; // bit periods per antenna while searching
    logic cal_en; // automatic rc calibration
    logic [7:0] cal_ival; // wakes between calibrations
    logic [SYNC_W-1:0] sync_word;
    logic [7:0] pre_thr; // alternating bits that make a preamble
  } rxw_cfg_t;

  typedef struct packed {
    logic rx_bit; // demodulated bit, valid with bit strobe
    logic rssi_above; // signal strength over threshold
    logic pkt_done; // packet handler finished
    logic pkt_ok; // finished packet was good
    logic ack_req; // acknowledge to be sent
    logic ack_done; // acknowledge sent
  } rxw_rf_t;

  typedef enum logic [2:0] {ST_OFF, ST_SLEEP, ST_SETTLE, ST_LISTEN, ST_PKT, ST_ACK} rxw_st_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_ALIGN, CAL_MEAS} rxw_cal_t;
endpackage
`default_nettype wire

// [hdl/rxw_sync_det.sv]
// sync word capture and preamble detector on the demodulated bit stream
`timescale 1ns/1ns
`default_nettype none
module rxw_sync_det (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic active,
  input wire logic bit_en,
  input wire logic rx_bit,
  input wire logic [rxw_pkg::SYNC_W-1:0] sync_word,
  input wire logic [7:0] pre_thr,
  output logic sync_hit,
  output logic pre_det
);
  import rxw_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] sh;
    logic [4:0] fill;
    logic [7:0] alt;
    logic hit;
    logic pre;
  } rxw_sd_t;

  rxw_sd_t s_q, s_d;

  // ==========================================================
  // shift, compare and count alternations
  always_comb begin
    s_d = s_q;
    s_d.hit = 1'b0;
    if (!active) begin
      s_d = '0;
    end else if (bit_en) begin
      s_d.sh = {s_q.sh[SYNC_W-2:0], rx_bit};
      if (s_q.fill != 5'(SYNC_W)) s_d.fill = s_q.fill + 5'h01;
      // locks on the word itself, no settling bytes needed
      if (s_q.fill >= 5'(SYNC_W - 1) && s_d.sh == sync_word) s_d.hit = 1'b1; // RULE12
      if (s_q.fill != 5'h00 && rx_bit != s_q.sh[0]) begin
        if (s_q.alt != 8'hFF) s_d.alt = s_q.alt + 8'h01;
      end else begin
        s_d.alt = 8'h00;
      end
      s_d.pre = (s_d.alt >= pre_thr) && (pre_thr != 8'h00); // RULE14
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (sys_rst) s_q <= '0;
    else s_q <= s_d;
  end

  assign sync_hit = s_q.hit;
  assign pre_det = s_q.pre;
endmodule
`default_nettype wire

// [hdl/rxw_wake_ctl.sv]
// wake polling, rc calibration and antenna diversity control
//
// Contract
// RULE1 - polls the receiver on the sleep timer alone, host stays out of it
// RULE2 - each wake enters receive, listens, sleeps again if no packet arrived
// RULE3 - sleep interval and listen window are programmable
// RULE4 - sleep timer value is captured for every received message
// RULE5 - sleep timer advances on rc oscillator periods, not the crystal
// RULE6 - optional rc recalibration repeats every programmed number of wakes
// RULE7 - with diversity on, one output drives the antenna switch
// RULE8 - optional complementary antenna select output
// RULE9 - antenna select toggles while searching, holds once signal is valid
// RULE10 - antenna select stays unchanged while an acknowledge is sent
// RULE11 - signal valid by strength threshold or preamble detector, configurable
// RULE12 - sync capture locks directly on the sync word
// RULE13 - receive settling after wake is four bit periods of agc
// RULE14 - sync logic doubles as preamble detector
// RULE15 - calibration trims the rc oscillator to nominal 40 kHz
// RULE16 - calibration brings the rc within 0.1 percent of reference
// RULE17 - sleep timer counts rc periods, wakes at the interval, restarts
// RULE18 - searching antenna dwells a programmable number of bit periods
`timescale 1ns/1ns
`default_nettype none
module rxw_wake_ctl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire rxw_pkg::rxw_cfg_t cfg,
  input wire rxw_pkg::rxw_rf_t rf,
  input wire logic rc_tick,
  output logic rx_en,
  output logic wake,
  output logic ant_sel,
  output logic ant_sel_n,
  output logic [15:0] ts,
  output logic ts_vld,
  output logic pkt_vld,
  output logic [7:0] rc_trim,
  output logic cal_ok,
  output logic pre_found
);
  import rxw_pkg::*;

  typedef struct packed {
    rxw_st_t st;
    rxw_cal_t cst;
    logic [15:0] slp;
    logic [15:0] win;
    logic [15:0] div;
    logic bit_en;
    logic [7:0] dwell;
    logic ant;
    logic ant_n;
    logic held;
    logic [15:0] ts;
    logic ts_vld;
    logic wake;
    logic pkt_vld;
    logic rx_en;
    logic [15:0] ccnt;
    logic [4:0] ticks;
    logic creq;
    logic [7:0] wcnt;
    logic [7:0] trim;
    logic cok;
    logic pre;
  } rxw_state_t;

  rxw_state_t s_q, s_d;
  logic sync_hit;
  logic pre_det;
  logic sd_active;
  logic sig_valid;

  // ==========================================================
  // sync and preamble detection
  assign sd_active = (s_q.st == ST_SETTLE) || (s_q.st == ST_LISTEN);
  assign sig_valid = cfg.valid_sel ? pre_det : rf.rssi_above; // RULE11

  rxw_sync_det u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .active(sd_active),
    .bit_en(s_q.bit_en),
    .rx_bit(rf.rx_bit),
    .sync_word(cfg.sync_word),
    .pre_thr(cfg.pre_thr),
    .sync_hit(sync_hit),
    .pre_det(pre_det)
  );

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.bit_en = 1'b0;
    s_d.wake = 1'b0;
    s_d.ts_vld = 1'b0;
    s_d.pkt_vld = 1'b0;
    s_d.pre = pre_det;

    // bit rate divider, only while the receiver is up
    if (s_q.st == ST_SETTLE || s_q.st == ST_LISTEN || s_q.st == ST_PKT) begin
      if (s_q.div >= cfg.bit_period - 16'h0001) begin
        s_d.div = 16'h0000;
        s_d.bit_en = 1'b1;
      end else begin
        s_d.div = s_q.div + 16'h0001;
      end
    end else begin
      s_d.div = 16'h0000;
    end

    // sleep timer on rc periods, free of any host action
    if (!cfg.wor_en) begin
      s_d.slp = 16'h0000;
    end else if (rc_tick) begin // RULE5
      if (s_q.slp >= cfg.sleep_ival - 16'h0001) begin // RULE3
        s_d.slp = 16'h0000; // RULE17
        s_d.wake = 1'b1; // RULE1
      end else begin
        s_d.slp = s_q.slp + 16'h0001;
      end
    end

    // receive sequencing
    case (s_q.st)
      ST_OFF: if (cfg.wor_en) s_d.st = ST_SLEEP;
      ST_SLEEP: begin
        if (!cfg.wor_en) begin
          s_d.st = ST_OFF;
        end else if (s_q.wake) begin
          s_d.st = ST_SETTLE; // RULE2
          s_d.win = 16'h0000;
          s_d.dwell = 8'h00;
          s_d.held = 1'b0;
        end
      end
      ST_SETTLE: begin
        if (s_q.bit_en) begin
          if (s_q.win == AGC_LAST) begin // RULE13
            s_d.st = ST_LISTEN;
            s_d.win = 16'h0000;
          end else begin
            s_d.win = s_q.win + 16'h0001;
          end
        end
      end
      ST_LISTEN: begin
        if (sync_hit) begin
          s_d.st = ST_PKT;
          s_d.ts = s_q.slp; // RULE4
          s_d.ts_vld = 1'b1;
        end else if (s_q.bit_en) begin
          if (s_q.win >= cfg.listen_bits - 16'h0001) s_d.st = ST_SLEEP; // RULE2
          else s_d.win = s_q.win + 16'h0001;
        end
      end
      ST_PKT: begin
        if (rf.pkt_done) begin
          s_d.pkt_vld = rf.pkt_ok;
          s_d.st = (rf.pkt_ok && rf.ack_req) ? ST_ACK : ST_SLEEP;
        end
      end
      ST_ACK: if (rf.ack_done) s_d.st = ST_SLEEP;
      default: s_d.st = ST_OFF;
    endcase
    s_d.rx_en = (s_d.st == ST_SETTLE) || (s_d.st == ST_LISTEN) || (s_d.st == ST_PKT);

    // antenna search: toggle per dwell until valid, then hold; frozen outside search
    if (!cfg.div_en) begin
      s_d.ant = 1'b0;
    end else if (sd_active && !s_q.held) begin // RULE7 RULE10
      if (sig_valid) begin
        s_d.held = 1'b1; // RULE9
      end else if (s_q.bit_en) begin
        if (s_q.dwell >= cfg.dwell_bits - 8'h01) begin // RULE18
          s_d.dwell = 8'h00;
          s_d.ant = ~s_q.ant; // RULE9
        end else begin
          s_d.dwell = s_q.dwell + 8'h01;
        end
      end
    end
    s_d.ant_n = cfg.diff_en ? ~s_d.ant : 1'b0; // RULE8

    // calibration scheduling; a new request wins over the clear
    if (s_q.cst == CAL_IDLE && cfg.cal_en && s_q.creq) s_d.creq = 1'b0;
    if (cfg.cal_en && s_q.wake) begin
      if (s_q.wcnt >= cfg.cal_ival - 8'h01) begin // RULE6
        s_d.wcnt = 8'h00;
        s_d.creq = 1'b1;
      end else begin
        s_d.wcnt = s_q.wcnt + 8'h01;
      end
    end

    // rc measurement: clocks over CAL_N rc periods against the crystal target
    case (s_q.cst)
      CAL_IDLE: if (cfg.cal_en && s_q.creq) s_d.cst = CAL_ALIGN;
      CAL_ALIGN: begin
        s_d.ccnt = 16'h0001; // the aligning cycle is the first one counted
        s_d.ticks = 5'h00;
        if (!cfg.cal_en) s_d.cst = CAL_IDLE;
        else if (rc_tick) s_d.cst = CAL_MEAS;
      end
      CAL_MEAS: begin
        s_d.ccnt = s_q.ccnt + 16'h0001;
        if (!cfg.cal_en) begin
          s_d.cst = CAL_IDLE;
        end else if (rc_tick) begin
          s_d.ticks = s_q.ticks + 5'h01;
          if (s_q.ticks == CAL_LAST) begin
            s_d.cst = CAL_IDLE;
            s_d.cok = 1'b0;
            if (s_q.ccnt > CAL_TARGET + CAL_TOL) begin // RULE16
              if (s_q.trim != TRIM_MAX) s_d.trim = s_q.trim + 8'h01; // RULE15
            end else if (s_q.ccnt < CAL_TARGET - CAL_TOL) begin
              if (s_q.trim != 8'h00) s_d.trim = s_q.trim - 8'h01; // RULE15
            end else begin
              s_d.cok = 1'b1; // RULE16
            end
          end
        end
      end
      default: s_d.cst = CAL_IDLE;
    endcase
  end

  // state register; calibration is requested once after reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.trim <= TRIM_RST;
      s_q.creq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign rx_en = s_q.rx_en;
  assign wake = s_q.wake;
  assign ant_sel = s_q.ant;
  assign ant_sel_n = s_q.ant_n;
  assign ts = s_q.ts;
  assign ts_vld = s_q.ts_vld;
  assign pkt_vld = s_q.pkt_vld;
  assign rc_trim = s_q.trim;
  assign cal_ok = s_q.cok;
  assign pre_found = s_q.pre;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_wake_settle: assert property ( // RULE2
    cfg.wor_en && s_q.st == ST_SLEEP && s_q.wake |=> s_q.st == ST_SETTLE && s_q.rx_en)
    else $error("wake did not start receive");
  chk_listen_end: assert property ( // RULE2
    s_q.st == ST_LISTEN && !sync_hit && s_q.bit_en && s_q.win >= cfg.listen_bits - 16'h0001
    |=> s_q.st == ST_SLEEP && !s_q.rx_en)
    else $error("listen window did not end in sleep");
  chk_settle_len: assert property ( // RULE13
    s_q.st != ST_LISTEN ##1 s_q.st == ST_LISTEN |-> $past(s_q.win) == AGC_LAST)
    else $error("settling not four bit periods");
  chk_timer_wrap: assert property ( // RULE17
    cfg.wor_en && rc_tick && s_q.slp >= cfg.sleep_ival - 16'h0001 |=> s_q.wake && s_q.slp == 16'h0000)
    else $error("sleep timer did not wrap with wake");
  chk_ts_capture: assert property ( // RULE4
    s_q.st == ST_LISTEN && sync_hit |=> s_q.ts_vld && s_q.ts == $past(s_q.slp) && s_q.st == ST_PKT)
    else $error("timestamp not captured on sync");
  chk_ant_ack: assert property ( // RULE10
    s_q.st == ST_ACK && cfg.div_en |=> $stable(s_q.ant))
    else $error("antenna changed during acknowledge");
  chk_ant_pair: assert property ( // RULE8
    cfg.diff_en && cfg.div_en ##1 cfg.diff_en |-> s_q.ant_n == ~s_q.ant)
    else $error("antenna pair not complementary");
  chk_ant_hold: assert property ( // RULE9
    cfg.div_en && sd_active && sig_valid |=> s_q.held ##1 (s_q.st != $past(s_q.st) || $stable(s_q.ant)))
    else $error("antenna not held after valid signal");
  chk_trim_slow: assert property ( // RULE16
    s_q.cst == CAL_MEAS && cfg.cal_en && rc_tick && s_q.ticks == CAL_LAST
    && s_q.ccnt > CAL_TARGET + CAL_TOL && s_q.trim != TRIM_MAX
    |=> s_q.trim == $past(s_q.trim) + 8'h01 && !s_q.cok)
    else $error("slow rc not trimmed up");

  cov_packet: cover property (s_q.st == ST_LISTEN ##1 s_q.st == ST_PKT);
  cov_ack: cover property (s_q.st == ST_ACK ##1 s_q.st == ST_SLEEP);
  cov_toggle: cover property (s_q.st == ST_LISTEN && $changed(s_q.ant));
  cov_cal_ok: cover property ($rose(s_q.cok));
endmodule
`default_nettype wire

// [verif/rxw_rf_model.sv]
// behavioural far side: rc oscillator ticks and demodulated bit stream
`timescale 1ns/1ns
`default_nettype none
module rxw_rf_model (
  input wire logic clock,
  input wire logic rx_en,
  input wire logic [15:0] rc_per,
  input wire logic [1:0] mode,
  input wire logic [15:0] sync_word,
  output logic rc_tick,
  output logic rx_bit
);
  int rc_cnt = 0;
  int k = 0;
  logic tick_q = 1'b0;
  logic bit_q = 1'b0;
  // outputs come from one process each, starting at a known level
  assign rc_tick = tick_q;
  assign rx_bit = bit_q;
  // ==========================================================
  // rc oscillator: one tick every rc_per system clocks, free running
  always @(posedge clock) begin
    rc_cnt <= (rc_cnt + 1 >= int'(rc_per)) ? 0 : rc_cnt + 1;
    tick_q <= #1 (rc_cnt + 1 >= int'(rc_per));
    k <= rx_en ? k + 1 : 0;
  end
  // ==========================================================
  // bits: silence, repeating sync word or alternating preamble;
  // a receiver that is off sees a bit that changes every cycle
  always @(posedge clock) begin
    if (rx_en !== 1'b1) begin
      bit_q <= #1 ~bit_q;
    end else if (mode == 2'h1) begin
      bit_q <= #1 sync_word[15 - (k % 16)];
    end else begin
      bit_q <= #1 (mode == 2'h2) && k[0];
    end
  end
endmodule
`default_nettype wire

// [verif/rx_wake_polling_diversity_ctl_tb.sv]
// self-checking bench of the wake polling and antenna diversity controller
`timescale 1ns/1ns
`default_nettype none
module rx_wake_polling_diversity_ctl_tb;
  import rxw_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  rxw_cfg_t cfg = '0;
  rxw_rf_t rf;
  logic [15:0] rc_per = 16'h02BC;
  logic [1:0] mode = 2'h0;
  logic rssi = 1'b0, pdone = 1'b0, pok = 1'b0, areq = 1'b0, adone = 1'b0;
  logic rc_tick, rx_bit, rx_en, wake, ant_sel, ant_sel_n, ts_vld, pkt_vld, cal_ok, pre_found;
  logic [15:0] ts;
  logic [7:0] rc_trim;
  logic [5:0] obs;
  int n_mismatch = 0, total_checks = 0, t0, chg, pf, len, ival, m, a;
  int ref_slp = 0, ref_prev = 0;
  longint tw, t;
  int pers[3] = '{700, 550, 625};
  assign rf = '{rx_bit: rx_bit, rssi_above: rssi, pkt_done: pdone, pkt_ok: pok,
                ack_req: areq, ack_done: adone};
  assign obs = {cal_ok, pre_found, pkt_vld, ts_vld, rx_en, wake};
  // reference sleep count: rc periods since the last wrap, cleared while polling is off
  always @(posedge clock) begin
    ref_prev <= ref_slp;
    if (sys_rst || !cfg.wor_en) begin
      ref_slp <= 0;
    end else if (rc_tick === 1'b1) begin
      ref_slp <= (ref_slp + 1 >= int'(cfg.sleep_ival)) ? 0 : ref_slp + 1;
    end
  end
  rxw_wake_ctl dut (.clock(clock), .sys_rst(sys_rst), .cfg(cfg), .rf(rf), .rc_tick(rc_tick),
    .rx_en(rx_en), .wake(wake), .ant_sel(ant_sel), .ant_sel_n(ant_sel_n), .ts(ts),
    .ts_vld(ts_vld), .pkt_vld(pkt_vld), .rc_trim(rc_trim), .cal_ok(cal_ok),
    .pre_found(pre_found));
  rxw_rf_model far (.clock(clock), .rx_en(rx_en), .rc_per(rc_per), .mode(mode),
    .sync_word(cfg.sync_word), .rc_tick(rc_tick), .rx_bit(rx_bit));
  initial begin
    forever #20 clock = ~clock;
  end
  // ==========================================================
  // checking, waiting and closing
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  // wait for an observed output to take a value, bounded
  task automatic wait_v(input int i, input logic v, input int lim);
    t0 = 0;
    while (obs[i] !== v) begin
      if (t0 >= lim) begin
        n_mismatch++;
        end_of_test();
      end
      tk(1);
      t0++;
    end
  endtask
  // one wake: antenna changes, preamble seen, receive length
  task automatic watch();
    logic s;
    chg = 0;
    pf = 0;
    len = 0;
    wait_v(0, 1'b1, 1200);
    tw = $time;
    wait_v(1, 1'b1, 1);
    s = ant_sel;
    while (rx_en === 1'b1 && len < 500) begin
      chk(ant_sel_n, cfg.diff_en & !ant_sel);
      chg += int'(ant_sel !== s);
      s = ant_sel;
      pf |= int'(pre_found === 1'b1);
      len++;
      tk(1);
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h416bf13f));
    cfg.cal_en = 1'b1;
    cfg.bit_period = 16'h0001;
    cfg.listen_bits = 16'h0028;
    tk(8);
    chk({rx_en, wake, ant_sel, ant_sel_n, ts_vld, pkt_vld, cal_ok}, 16'h0000);
    chk(rc_trim, 16'h0080);
    // calibration against slow, fast and exact rc periods
    foreach (pers[i]) begin
      sys_rst = 1'b1;
      rc_per = 16'(pers[i]);
      tk(2);
      sys_rst = 1'b0;
      tk(12500);
      m = 16 * pers[i];
      chk(rc_trim, m > CAL_TARGET + CAL_TOL ? 8'h81 : m < CAL_TARGET - CAL_TOL ? 8'h7F : 8'h80);
      chk(cal_ok, m <= CAL_TARGET + CAL_TOL && m >= CAL_TARGET - CAL_TOL);
    end
    // polling without host action: spacing and receive window
    cfg.cal_en = 1'b0;
    rc_per = 16'h0064;
    ival = $urandom_range(2, 5);
    cfg.sleep_ival = 16'(ival);
    cfg.sync_word = 16'($urandom) | 16'h0003;
    cfg.wor_en = 1'b1;
    wait_v(0, 1'b1, 1200);
    t = $time;
    tk(1);
    watch();
    chk(16'((tw - t) / 40), 16'(ival * 100));
    chk(len >= 44 && len <= 46, 1);
    chk(chg, 0);
    // diversity: search, strength hold, preamble hold
    cfg.div_en = 1'b1;
    cfg.diff_en = 1'b1;
    cfg.dwell_bits = 8'h03;
    watch();
    chk(chg >= 13 && chg <= 15, 1);
    rssi = 1'b1;
    watch();
    chk(chg <= 1, 1);
    rssi = 1'b0;
    cfg.valid_sel = 1'b1;
    cfg.pre_thr = 8'h08;
    mode = 2'h2;
    watch();
    chk(chg >= 1 && chg <= 4 && pf == 1, 1);
    // sync capture, timestamp, packet outcome and acknowledge
    cfg.valid_sel = 1'b0;
    mode = 2'h1;
    rc_per = 16'h000A; // sleep count advances between wake and sync capture
    for (int k = 0; k < 3; k++) begin
      wait_v(2, 1'b1, 1200);
      chk(ts, 16'(ref_prev));
      a = ant_sel;
      pdone = 1'b1;
      pok = (k != 2);
      areq = (k == 1);
      tk(1);
      pdone = 1'b0;
      chk(pkt_vld, k != 2);
      chk(rx_en, 0);
      tk(6);
      adone = areq;
      tk(1);
      adone = 1'b0;
      tk(2);
      chk(ant_sel, a);
    end
    // calibration repeats after the programmed number of wakes; fast rc steps trim down
    cfg.cal_en = 1'b1;
    cfg.cal_ival = 8'h02;
    wait_v(0, 1'b1, 1200);
    tk(1);
    wait_v(0, 1'b1, 1200);
    tk(1);
    cfg.cal_ival = 8'hFF; // no further request within the rest of the run
    tk(250);
    chk(rc_trim, 16'h007F);
    chk(cal_ok, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
